// file: rtl/iers_pkg.sv
// Package of constants and types for the interrupt entry and return sequencer
package iers_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int NUM_SRC  = 8;
  localparam int PC_W     = 24;
  localparam int SP_W     = 16;
  localparam int SRC_W    = 3;

  // ********************************************************
  // Timing counts in clock cycles, and the number of program counter bytes stacked
  // ********************************************************
  localparam logic [3:0] ENTRY_CYCLES  = 4'h5;
  localparam logic [3:0] WAKE_EXTRA    = 4'h5;
  localparam logic [3:0] JUMP_CYCLES   = 4'h3;
  localparam logic [3:0] RETURN_CYCLES = 4'h5;
  localparam logic [SP_W-1:0] PC_BYTES = 16'h0003;

  // ********************************************************
  // Reset values and vector layout
  // ********************************************************
  localparam logic [SP_W-1:0] SP_RESET  = 16'hffff;
  localparam logic [PC_W-1:0] VEC_STEP  = 24'h000002;
  localparam logic [PC_W-1:0] VEC_FIRST = 24'h000002;

  // ********************************************************
  // Sequencer states
  // ********************************************************
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_WAKE   = 3'b001,
    ST_ENTRY  = 3'b010,
    ST_JUMP   = 3'b011,
    ST_RETURN = 3'b100
  } iers_state_t;

endpackage

// file: rtl/iers_stack_if.sv
// Interface carrying stack pushes and pops between the sequencer and its stack store
`timescale 1ns/100ps
`default_nettype none
interface iers_stack_if;
  logic                          push;
  logic                          pop;
  logic [iers_pkg::SP_W-1:0]     addr;
  logic [7:0]                    wrData;
  logic [7:0]                    rdData;
  modport seq (output push, output pop, output addr, output wrData, input rdData);
  modport mem (input push, input pop, input addr, input wrData, output rdData);
endinterface
`default_nettype wire

// file: rtl/iers_stack_mem.sv
// Small byte-wide stack store with registered read data
`timescale 1ns/100ps
`default_nettype none
module iers_stack_mem (
  // Clock
  input wire logic    ref_clk,
  // Stack access
  iers_stack_if.mem   stk
);

  logic [7:0] store [0:255];
  logic [7:0] rdReg;

  // ********************************************************
  // Write on push, registered read on pop
  // ********************************************************
  always_ff @(posedge ref_clk) begin
    if (stk.push) begin
      store[stk.addr[7:0]] <= stk.wrData;
    end
    if (stk.pop) begin
      rdReg <= store[stk.addr[7:0]];
    end
  end

  assign stk.rdData = rdReg;

endmodule
`default_nettype wire

// file: rtl/iers_sequencer.sv
// Interrupt entry and return sequencer for an 8-bit core
`timescale 1ns/100ps
`default_nettype none
module iers_sequencer (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_b,
  // Interrupt sources
  input  wire logic [iers_pkg::NUM_SRC-1:0]  srcRequest,
  input  wire logic [iers_pkg::NUM_SRC-1:0]  srcEnable,
  input  wire logic [iers_pkg::NUM_SRC-1:0]  srcIsFlag,
  output logic      [iers_pkg::NUM_SRC-1:0]  srcFlagClear,
  // Instruction sequencer
  input  wire logic                          instrBoundary,
  input  wire logic                          instrSetGie,
  input  wire logic                          instrClearGie,
  input  wire logic                          instrReturn,
  input  wire logic                          coreSleeping,
  input  wire logic [iers_pkg::PC_W-1:0]     curPc,
  output logic                               coreHold,
  output logic                               pcLoad,
  output logic      [iers_pkg::PC_W-1:0]     pcLoadValue,
  output logic                               wakeUp,
  // Status
  output logic                               globalEnable,
  output logic      [iers_pkg::SP_W-1:0]     stackPtr
);

  iers_stack_if stk ();

  iers_stack_mem u_stack (
    .ref_clk (ref_clk),
    .stk     (stk)
  );

  // ********************************************************
  // State
  // ********************************************************
  iers_pkg::iers_state_t            state_reg, state_next;
  logic [3:0]                       cnt_reg, cnt_next;
  logic                             gie_reg, gie_next;
  logic                             shield_reg, shield_next;
  logic [iers_pkg::SP_W-1:0]        sp_reg, sp_next;
  logic [iers_pkg::PC_W-1:0]        pcHold_reg, pcHold_next;
  logic [iers_pkg::SRC_W-1:0]       src_reg, src_next;
  logic [iers_pkg::NUM_SRC-1:0]     fclr_reg, fclr_next;
  logic                             hold_reg, hold_next;
  logic                             load_reg, load_next;
  logic [iers_pkg::PC_W-1:0]        loadVal_reg, loadVal_next;
  logic                             wake_reg, wake_next;
  logic [iers_pkg::NUM_SRC-1:0]     reqSync1_reg, reqSync2_reg;

  // Lowest-numbered eligible source
  function automatic logic [iers_pkg::SRC_W-1:0] pickSrc(
    input logic [iers_pkg::NUM_SRC-1:0] live
  );
    logic [iers_pkg::SRC_W-1:0] sel;
    sel = '0;
    for (int i = iers_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        sel = iers_pkg::SRC_W'(i);
      end
    end
    return sel;
  endfunction

  logic [iers_pkg::NUM_SRC-1:0] live;
  logic                         take;
  logic [iers_pkg::PC_W-1:0]    vecAddr;

  // ********************************************************
  // Next-state logic
  // ********************************************************
  always_comb begin
    live         = reqSync2_reg & srcEnable;
    take = gie_reg && (live != '0) && instrBoundary && !shield_reg;
    vecAddr      = iers_pkg::VEC_FIRST
                   + iers_pkg::VEC_STEP * iers_pkg::PC_W'(src_reg);
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    gie_next     = gie_reg;
    shield_next  = shield_reg;
    sp_next      = sp_reg;
    pcHold_next  = pcHold_reg;
    src_next     = src_reg;
    fclr_next    = '0;
    hold_next    = 1'b0;
    load_next    = 1'b0;
    loadVal_next = loadVal_reg;
    wake_next    = 1'b0;
    stk.push     = 1'b0;
    stk.pop      = 1'b0;
    stk.addr     = sp_reg;
    stk.wrData   = 8'h00;
    case (state_reg)
      iers_pkg::ST_RUN: begin
        // One instruction runs after a return or an enable before the shield drops
        if (instrBoundary) begin
          shield_next = 1'b0;
        end
        if (instrClearGie) begin
          gie_next = 1'b0;
        end else if (instrSetGie && !gie_reg) begin
          gie_next    = 1'b1;
          shield_next = 1'b1;
        end
        if (coreSleeping && gie_reg && (live != '0)) begin
          state_next = iers_pkg::ST_WAKE;
          cnt_next   = iers_pkg::WAKE_EXTRA - 4'h1;
          src_next   = pickSrc(live);
          pcHold_next = curPc;
          gie_next   = 1'b0;
          hold_next  = 1'b1;
          wake_next  = 1'b1;
        end else if (take) begin
          state_next  = iers_pkg::ST_ENTRY;
          cnt_next    = iers_pkg::ENTRY_CYCLES - 4'h1;
          src_next    = pickSrc(live);
          pcHold_next = curPc;
          gie_next    = 1'b0;
          hold_next   = 1'b1;
        end else if (instrReturn && instrBoundary) begin
          state_next = iers_pkg::ST_RETURN;
          cnt_next   = iers_pkg::RETURN_CYCLES - 4'h1;
          hold_next  = 1'b1;
        end
      end
      iers_pkg::ST_WAKE: begin
        hold_next = 1'b1;
        if (cnt_reg == 4'h0) begin
          state_next = iers_pkg::ST_ENTRY;
          cnt_next   = iers_pkg::ENTRY_CYCLES - 4'h1;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      iers_pkg::ST_ENTRY: begin
        hold_next = 1'b1;
        // Three program counter bytes pushed, low byte first, stack grows down
        if (cnt_reg >= 4'h2) begin
          stk.push   = 1'b1;
          stk.wrData = pcHold_reg[8*(4-cnt_reg)+:8];
          sp_next    = sp_reg - 16'h0001;
        end
        if (cnt_reg == 4'h1) begin
          fclr_next[src_reg] = srcIsFlag[src_reg];
        end
        if (cnt_reg == 4'h0) begin
          state_next   = iers_pkg::ST_JUMP;
          cnt_next     = iers_pkg::JUMP_CYCLES - 4'h1;
          load_next    = 1'b1;
          loadVal_next = vecAddr;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      iers_pkg::ST_JUMP: begin
        // Vector jump occupies the core; the sequencer just waits it out
        if (cnt_reg == 4'h0) begin
          state_next = iers_pkg::ST_RUN;
        end else begin
          hold_next = 1'b1;
          cnt_next  = cnt_reg - 4'h1;
        end
      end
      iers_pkg::ST_RETURN: begin
        hold_next = 1'b1;
        // Pop high byte first, three reads, registered data lands next cycle
        if (cnt_reg >= 4'h2) begin
          stk.pop  = 1'b1;
          stk.addr = sp_reg + 16'h0001 + 16'(4'h4 - cnt_reg);
        end
        if (cnt_reg <= 4'h3 && cnt_reg >= 4'h1) begin
          loadVal_next[8*(cnt_reg-4'h1)+:8] = stk.rdData;
        end
        if (cnt_reg == 4'h0) begin
          state_next  = iers_pkg::ST_RUN;
          sp_next     = sp_reg + iers_pkg::PC_BYTES;
          gie_next    = 1'b1;
          shield_next = 1'b1;
          load_next   = 1'b1;
          hold_next   = 1'b0;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = iers_pkg::ST_RUN;
      end
    endcase
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= iers_pkg::ST_RUN;
      cnt_reg      <= 4'h0;
      gie_reg      <= 1'b0;
      shield_reg   <= 1'b0;
      sp_reg       <= iers_pkg::SP_RESET;
      pcHold_reg   <= '0;
      src_reg      <= '0;
      fclr_reg     <= '0;
      hold_reg     <= 1'b0;
      load_reg     <= 1'b0;
      loadVal_reg  <= '0;
      wake_reg     <= 1'b0;
      reqSync1_reg <= '0;
      reqSync2_reg <= '0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      gie_reg      <= gie_next;
      shield_reg   <= shield_next;
      sp_reg       <= sp_next;
      pcHold_reg   <= pcHold_next;
      src_reg      <= src_next;
      fclr_reg     <= fclr_next;
      hold_reg     <= hold_next;
      load_reg     <= load_next;
      loadVal_reg  <= loadVal_next;
      wake_reg     <= wake_next;
      reqSync1_reg <= srcRequest;   // Requests come from pins and peripherals
      reqSync2_reg <= reqSync1_reg;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign srcFlagClear = fclr_reg;
  assign coreHold     = hold_reg;
  assign pcLoad       = load_reg;
  assign pcLoadValue  = loadVal_reg;
  assign wakeUp       = wake_reg;
  assign globalEnable = gie_reg;
  assign stackPtr     = sp_reg;

endmodule
`default_nettype wire

// file: test/iers_sequencer_assertions.sv
// Port checks for the interrupt entry and return sequencer
`timescale 1ns/100ps
`default_nettype none
module iers_sequencer_assertions (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Sources and core
  input wire logic [7:0]  srcIsFlag,
  input wire logic [7:0]  srcFlagClear,
  input wire logic        instrBoundary,
  input wire logic        instrSetGie,
  input wire logic        instrReturn,
  input wire logic        coreSleeping,
  // Outputs
  input wire logic        coreHold,
  input wire logic        pcLoad,
  input wire logic        globalEnable,
  input wire logic [15:0] stackPtr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Start of an entry stall, and a return decoded while running
  sequence s_ent; $rose(coreHold) && !$past(instrReturn) && !$past(coreSleeping); endsequence
  sequence s_ret; instrReturn && instrBoundary && !coreHold; endsequence
  // Entry, jump, return, wake and enable checks
  property p_ent; s_ent |-> (coreHold && !pcLoad)[*5] ##1 (pcLoad && coreHold) ##1 coreHold[*2]
    ##1 !coreHold; endproperty
  a_ent: assert property (p_ent) else $error("entry timing");
  property p_push; s_ent |-> ##3 stackPtr == $past(stackPtr, 4) - 16'h0003; endproperty
  a_push: assert property (p_push) else $error("push count");
  property p_gie; s_ent |-> !globalEnable && $past(globalEnable) && $past(instrBoundary); endproperty
  a_gie: assert property (p_gie) else $error("entry enable");
  property p_sei; instrSetGie && instrBoundary && !coreHold && !globalEnable |=> !coreHold
    ##1 !coreHold; endproperty
  a_sei: assert property (p_sei) else $error("entry after enable");
  property p_ret; s_ret |=> (coreHold && !pcLoad)[*5] ##1 (!coreHold && pcLoad); endproperty
  a_ret: assert property (p_ret) else $error("return timing");
  property p_rsp; s_ret |-> ##6 stackPtr == $past(stackPtr, 6) + 16'h0003
    && globalEnable; endproperty
  a_rsp: assert property (p_rsp) else $error("return pointer");
  property p_flg; srcFlagClear != 8'h00 |-> $onehot(srcFlagClear) && !(srcFlagClear & ~srcIsFlag)
    && coreHold; endproperty
  a_flg: assert property (p_flg) else $error("flag clear");
  property p_wake; $rose(coreHold) && $past(coreSleeping) |-> (coreHold && !pcLoad)[*5]
    ##1 (coreHold && !pcLoad)[*5] ##1 pcLoad; endproperty
  a_wake: assert property (p_wake) else $error("wake latency");
endmodule
bind iers_sequencer iers_sequencer_assertions u_iers_sequencer_assertions (
  .ref_clk(ref_clk), .rst_b(rst_b), .srcIsFlag(srcIsFlag), .srcFlagClear(srcFlagClear),
  .instrBoundary(instrBoundary), .instrSetGie(instrSetGie), .instrReturn(instrReturn),
  .coreSleeping(coreSleeping), .coreHold(coreHold), .pcLoad(pcLoad),
  .globalEnable(globalEnable), .stackPtr(stackPtr));
`default_nettype wire

// file: test/iers_core_model.sv
// Instruction completion model of the core beside the sequencer
`timescale 1ns/100ps
`default_nettype none
module iers_core_model (
  // Clock, reset and core state
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       coreHold,
  input  wire logic       coreSleeping,
  input  wire logic [3:0] instrLen,
  // Completion strobe
  output logic            instrBoundary
);
  logic [3:0] cntReg;
  logic [3:0] cntNext;
  // Restart while stalled, asleep or at an instruction's last cycle
  always_comb begin
    cntNext = (coreHold || coreSleeping || instrBoundary) ? 4'h0 : cntReg + 4'h1;
  end
  // Cycle count register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cntReg <= 4'h0;
    end else begin
      cntReg <= cntNext;
    end
  end
  // Multi-cycle instructions complete only on their last cycle
  assign instrBoundary = !coreHold && !coreSleeping && (cntReg == instrLen - 4'h1);
endmodule
`default_nettype wire

// file: test/iers_sequencer_tb_top.sv
// Self-checking bench for the interrupt entry and return sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
module iers_sequencer_tb_top;
  logic        ref_clk = 1'b0, rst_b = 1'b0, instrSetGie = 1'b0, instrClearGie = 1'b0;
  logic        instrReturn = 1'b0, coreSleeping = 1'b0, wakeSeen = 1'b0;
  logic [7:0]  srcRequest = 8'h00, srcEnable = 8'hfd, srcIsFlag = 8'h08, flagAcc = 8'h00;
  logic [23:0] curPc = 24'h3c5a96;
  logic [3:0]  instrLen = 4'h1;
  logic [7:0]  srcFlagClear;
  logic [23:0] pcLoadValue;
  logic [15:0] stackPtr;
  logic        instrBoundary, coreHold, pcLoad, wakeUp, globalEnable;
  int          failures = 0, checked = 0, cycles = 0, boundCnt = 0;
  // Clock
  always #2 ref_clk = ~ref_clk;
  // Design and core model
  iers_sequencer u_iers_sequencer (.ref_clk(ref_clk), .rst_b(rst_b), .srcRequest(srcRequest),
    .srcEnable(srcEnable), .srcIsFlag(srcIsFlag), .srcFlagClear(srcFlagClear),
    .instrBoundary(instrBoundary), .instrSetGie(instrSetGie), .instrClearGie(instrClearGie),
    .instrReturn(instrReturn), .coreSleeping(coreSleeping), .curPc(curPc),
    .coreHold(coreHold), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .wakeUp(wakeUp),
    .globalEnable(globalEnable), .stackPtr(stackPtr));
  iers_core_model u_iers_core_model (.ref_clk(ref_clk), .rst_b(rst_b), .coreHold(coreHold),
    .coreSleeping(coreSleeping), .instrLen(instrLen), .instrBoundary(instrBoundary));
  // Wake monitor and hang limit
  always @(negedge ref_clk) begin
    if (wakeUp === 1'b1) wakeSeen = 1'b1;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end
  // Wait for hold high (0), load (1) or hold low (2), counting free boundaries
  task automatic wait_hi(input int sel, output int n);
    n = 0;
    while (n < 60 && ((sel == 0) ? coreHold : (sel == 1) ? pcLoad : !coreHold) !== 1'b1) begin
      flagAcc = flagAcc | srcFlagClear;
      @(negedge ref_clk);
      boundCnt = boundCnt + int'(instrBoundary === 1'b1 && coreHold === 1'b0);
      n++;
    end
  endtask
  task automatic gie(input logic s, input logic c);
    @(posedge ref_clk) {instrSetGie, instrClearGie} <= {s, c};
    @(posedge ref_clk) {instrSetGie, instrClearGie} <= 2'b00;
  endtask
  task automatic wait_entry(input logic [23:0] vec, input int lat, input logic [7:0] flg);
    int n;
    wait_hi(0, n);
    flagAcc = 8'h00;
    wait_hi(1, n);
    `CHK(n, lat)
    `CHK(pcLoadValue, vec)
    `CHK(flagAcc | srcFlagClear, flg)
    `CHK({globalEnable, stackPtr}, 17'h0fffc)
  endtask
  task automatic do_return();
    int n;
    wait_hi(2, n);
    @(posedge ref_clk) instrReturn <= 1'b1;
    @(posedge ref_clk) instrReturn <= 1'b0;
    wait_hi(1, n);
    `CHK({pcLoadValue, stackPtr, globalEnable}, {curPc, 16'hffff, 1'b1})
    boundCnt = 0;
    wait_hi(2, n);
  endtask
  task automatic t_refuse();
    gie(1'b1, 1'b0);
    @(posedge ref_clk) srcRequest <= 8'h02;
    repeat (20) @(negedge ref_clk);
    `CHK({coreHold, globalEnable}, 2'b01)
    gie(1'b1, 1'b1);
    @(posedge ref_clk) srcRequest <= 8'h08;
    repeat (20) @(negedge ref_clk);
    `CHK({coreHold, globalEnable}, 2'b00)
    $display("refuse test done");
  endtask
  task automatic t_shield();
    gie(1'b1, 1'b0);
    boundCnt = 0;
    wait_entry(24'h000008, 5, 8'h08);
    `CHK(boundCnt >= 1, 1'b1)
    @(posedge ref_clk) srcRequest <= 8'h00;
    do_return();
    @(posedge ref_clk) srcRequest <= 8'h24;
    wait_entry(24'h000006, 5, 8'h00);
    @(posedge ref_clk) srcRequest <= 8'h20;
    do_return();
    wait_entry(24'h00000c, 5, 8'h00);
    `CHK(boundCnt >= 1, 1'b1)
    @(posedge ref_clk) srcRequest <= 8'h00;
    do_return();
    $display("shield and priority test done");
  endtask
  task automatic t_slow();
    @(posedge ref_clk) {instrLen, srcRequest} <= {4'h4, 8'h01};
    wait_entry(24'h000002, 5, 8'h00);
    @(posedge ref_clk) {instrLen, srcRequest} <= {4'h1, 8'h00};
    do_return();
    @(posedge ref_clk) coreSleeping <= 1'b1;
    @(posedge ref_clk) srcRequest <= 8'h10;
    wait_entry(24'h00000a, 10, 8'h00);
    `CHK(wakeSeen, 1'b1)
    @(posedge ref_clk) {coreSleeping, srcRequest} <= 9'h000;
    do_return();
    $display("multi-cycle and sleep test done");
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK({coreHold, pcLoad, globalEnable, stackPtr}, 19'h0ffff)
    t_refuse();
    t_shield();
    t_slow();
    stop_test();
  end
endmodule
`default_nettype wire
